// *** src/clock_output_enable_cfg.svh ***
`ifndef CLOCK_OUTPUT_ENABLE_CFG_SVH
`define CLOCK_OUTPUT_ENABLE_CFG_SVH

// Address byte with the write bit in bit 0.
`define SLAVE_ADDR_BYTE   8'hd2
// Address, command code and byte count come before register 0.
`define HEADER_BYTES      4'h3
`define BYTE_BITS         4'h8
`define BYTE_IDX_MAX      4'hf

`define REG_EXTRA_MEM     4'h4
`define REG_PERIPH        4'h5
`define REG_SPARE         4'h6

`define MEM_EN_MSB        3
`define MEM_EN_LSB        0
`define INT_REF_EN_BIT    4
`define SECOND_REF_EN_BIT 1
`define FIRST_REF_EN_BIT  0

`define MEM_EN_DEFAULT    4'hf
`define PERIPH_EN_DEFAULT 1'b1

`endif

// *** src/clock_output_enable_pkg.sv ***
package clock_output_enable_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_ACK  = 4'b0100,
    ST_SKIP = 4'b1000
  } rx_state_t;

  // Packs to 7 bits: mem[3:0] on bits 6:3, then the three references.
  typedef struct packed {
    logic [3:0] mem;
    logic       intRef;
    logic       secondRef;
    logic       firstRef;
  } clk_enables_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_sample_t;

endpackage

// *** src/gated_clock_out.sv ***
`timescale 1ns/1ps
module gated_clock_out (
  input  wire logic srcClk,   // Link clock that is gated.
  input  wire logic linkRst,  // Reset already synchronised to srcClk.
  input  wire logic enable,   // Enable level from the mclk domain.
  output logic      clkOut    // Gated clock at half the srcClk rate.
);

  logic enS1_ff;
  logic enS2_ff;
  logic out_ff;

  always_ff @(posedge srcClk) begin
    if (linkRst) begin
      enS1_ff <= 1'b0;
      enS2_ff <= 1'b0;
    end else begin
      enS1_ff <= enable;
      enS2_ff <= enS1_ff;
    end
  end

  // The enable is looked at only while the output is low, so a high
  // phase is never cut short and a stopped output rests low.
  always_ff @(posedge srcClk) begin
    if (linkRst) begin
      out_ff <= 1'b0;
    end else if (out_ff) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= enS2_ff;
    end
  end

  assign clkOut = out_ff;

  a_high_full: assert property (
    @(posedge srcClk) disable iff (linkRst)
    out_ff |=> !out_ff ##1 (out_ff == $past(enS2_ff)))
    else $error("gated clock high phase not one full cycle");

  a_stop_low: assert property (
    @(posedge srcClk) disable iff (linkRst)
    (!enS2_ff && !out_ff) |=> !out_ff)
    else $error("stopped clock output did not stay low");

  a_start_run: assert property (
    @(posedge srcClk) disable iff (linkRst)
    (enS2_ff && !out_ff) |=> out_ff)
    else $error("enabled clock output did not start");

endmodule

// *** src/clock_output_enable_regs.sv ***
// Behaviour
// - Memory-clock enable bit: one runs the output, zero stops it.
// - Bits 3..0 gate memory clocks eleven..eight; all power up as one.
// - Bits 7..4 of extra memory register are reserved and affect nothing.
// - Peripheral register: one runs, zero stops; bits 7,6,5,3,2 reserved.
// - Peripheral bit 4 gates interrupt-controller reference, default one.
// - Peripheral bit 1 gates second reference output, default one.
// - Peripheral bit 0 gates first reference output, default one.
// - Register six is reserved; its byte is acknowledged and changes nothing.
// - Write-only slave; address byte checked; each byte acknowledged low.
// - Command and count bytes acknowledged, then registers from zero upward.
// - Defaults load only at power-up, never by a later transaction.
`timescale 1ns/1ps
`include "clock_output_enable_cfg.svh"
module clock_output_enable_regs
  import clock_output_enable_pkg::*;
(
  input  wire logic mclk,                  // System clock, 50 MHz.
  input  wire logic rst,                   // Power-up reset, high, sync.
  input  wire logic srcClk,                // Link clock being gated.
  input  wire logic sclIn,                 // Serial clock pin level.
  input  wire logic sdaIn,                 // Serial data pin level.
  output logic      sdaOut,                // Serial data drive value.
  output logic      sdaOe,                 // High while pulling data low.
  output logic      memoryClockEleven,     // Gated memory clock 11.
  output logic      memoryClockTen,        // Gated memory clock 10.
  output logic      memoryClockNine,       // Gated memory clock 9.
  output logic      memoryClockEight,      // Gated memory clock 8.
  output logic      interruptCtrlRefClock, // Gated interrupt ref clock.
  output logic      secondReferenceOut,    // Gated second reference.
  output logic      firstReferenceOut      // Gated first reference.
);

  line_sample_t lineS1_ff;
  line_sample_t lineS2_ff;
  line_sample_t lineD_ff;
  rx_state_t    state_ff;
  logic [3:0]   bitCnt_ff;
  logic [3:0]   byteIdx_ff;
  logic [7:0]   shift_ff;
  logic         sdaOe_ff;
  logic         sdaOut_ff;
  logic         regWr_ff;
  logic [3:0]   regNum_ff;
  clk_enables_t en_ff;
  logic         linkRstS1_ff;
  logic         linkRstS2_ff;
  logic         startSeen;
  logic         stopSeen;
  logic         sclRise;
  logic         sclFall;
  logic [6:0]   enVec;
  logic [6:0]   clkVec;

  // Register number carried by a byte position after the header bytes.
  function automatic logic [3:0] regOf(input logic [3:0] idx);
    regOf = idx - `HEADER_BYTES;
  endfunction

  function automatic logic isRegByte(input logic [3:0] idx);
    isRegByte = (idx >= `HEADER_BYTES);
  endfunction

  // Pins are asynchronous to mclk; only the second stage and its delayed copy are looked at.
  always_ff @(posedge mclk) begin
    if (rst) begin
      lineS1_ff <= '{scl: 1'b1, sda: 1'b1};
      lineS2_ff <= '{scl: 1'b1, sda: 1'b1};
      lineD_ff  <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      lineS1_ff <= '{scl: sclIn, sda: sdaIn};
      lineS2_ff <= lineS1_ff;
      lineD_ff  <= lineS2_ff;
    end
  end

  assign startSeen = lineD_ff.scl & lineS2_ff.scl
                   & lineD_ff.sda & ~lineS2_ff.sda;
  assign stopSeen  = lineD_ff.scl & lineS2_ff.scl
                   & ~lineD_ff.sda & lineS2_ff.sda;
  assign sclRise   = lineS2_ff.scl & ~lineD_ff.scl;
  assign sclFall   = ~lineS2_ff.scl & lineD_ff.scl;

  // Byte receiver. A wrong address or a read request is left without
  // acknowledge and the rest of the transfer is ignored until a start or a stop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      bitCnt_ff  <= 4'h0;
      byteIdx_ff <= 4'h0;
      shift_ff   <= 8'h00;
      sdaOe_ff   <= 1'b0;
      regWr_ff   <= 1'b0;
      regNum_ff  <= 4'h0;
    end else begin
      regWr_ff <= 1'b0;
      if (stopSeen) begin
        state_ff <= ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else if (startSeen) begin
        state_ff   <= ST_RECV;
        bitCnt_ff  <= 4'h0;
        byteIdx_ff <= 4'h0;
        sdaOe_ff   <= 1'b0;
      end else begin
        case (state_ff)
          ST_RECV: begin
            if (sclRise && bitCnt_ff != `BYTE_BITS) begin
              shift_ff  <= {shift_ff[6:0], lineS2_ff.sda};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == `BYTE_BITS) begin
              if (byteIdx_ff == 4'h0 && shift_ff != `SLAVE_ADDR_BYTE) begin
                state_ff <= ST_SKIP;
              end else begin
                state_ff <= ST_ACK;
                sdaOe_ff <= 1'b1;
                if (isRegByte(byteIdx_ff)) begin
                  regWr_ff  <= 1'b1;
                  regNum_ff <= regOf(byteIdx_ff);
                end
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              sdaOe_ff  <= 1'b0;
              bitCnt_ff <= 4'h0;
              state_ff  <= ST_RECV;
              if (byteIdx_ff != `BYTE_IDX_MAX) begin
                byteIdx_ff <= byteIdx_ff + 4'h1;
              end
            end
          end
          ST_IDLE, ST_SKIP: begin
            state_ff <= state_ff;
          end
          default: begin
            state_ff <= ST_IDLE;
            sdaOe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // The data line is only ever pulled low; the drive value is constant.
  always_ff @(posedge mclk) begin
    sdaOut_ff <= 1'b0;
  end

  // Enables load their defaults only from the power-up reset; bytes for
  // registers below four belong to other banks and are not kept here.
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_ff <= '{mem:       `MEM_EN_DEFAULT,
                 intRef:    `PERIPH_EN_DEFAULT,
                 secondRef: `PERIPH_EN_DEFAULT,
                 firstRef:  `PERIPH_EN_DEFAULT};
    end else if (regWr_ff) begin
      case (regNum_ff)
        `REG_EXTRA_MEM: begin
          en_ff.mem <= shift_ff[`MEM_EN_MSB:`MEM_EN_LSB];
        end
        `REG_PERIPH: begin
          en_ff.intRef    <= shift_ff[`INT_REF_EN_BIT];
          en_ff.secondRef <= shift_ff[`SECOND_REF_EN_BIT];
          en_ff.firstRef  <= shift_ff[`FIRST_REF_EN_BIT];
        end
        `REG_SPARE: begin
          en_ff <= en_ff;
        end
        default: begin
          en_ff <= en_ff;
        end
      endcase
    end
  end

  // Reset reaches the link domain through two stages of its own.
  always_ff @(posedge srcClk) begin
    linkRstS1_ff <= rst;
    linkRstS2_ff <= linkRstS1_ff;
  end

  assign enVec = en_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_gate
      gated_clock_out u_gate (
        .srcClk  (srcClk),
        .linkRst (linkRstS2_ff),
        .enable  (enVec[gi]),
        .clkOut  (clkVec[gi])
      );
    end
  endgenerate

  assign memoryClockEleven     = clkVec[6];
  assign memoryClockTen        = clkVec[5];
  assign memoryClockNine       = clkVec[4];
  assign memoryClockEight      = clkVec[3];
  assign interruptCtrlRefClock = clkVec[2];
  assign secondReferenceOut    = clkVec[1];
  assign firstReferenceOut     = clkVec[0];
  assign sdaOe                 = sdaOe_ff;
  assign sdaOut                = sdaOut_ff;

  a_mem_default: assert property (
    @(posedge mclk)
    rst |=> (en_ff.mem == `MEM_EN_DEFAULT))
    else $error("memory clock enables not all one after reset");

  a_periph_default: assert property (
    @(posedge mclk)
    rst |=> (en_ff.intRef && en_ff.secondRef && en_ff.firstRef))
    else $error("peripheral enables not one after reset");

  a_mem_write: assert property (
    @(posedge mclk) disable iff (rst)
    (regWr_ff && regNum_ff == `REG_EXTRA_MEM)
      |=> (en_ff.mem == $past(shift_ff[3:0])))
    else $error("memory enables not loaded from written byte");

  a_mem_reserved: assert property (
    @(posedge mclk) disable iff (rst)
    (regWr_ff && regNum_ff == `REG_EXTRA_MEM)
      |=> $stable({en_ff.intRef, en_ff.secondRef, en_ff.firstRef}))
    else $error("extra memory byte disturbed other enables");

  a_periph_write: assert property (
    @(posedge mclk) disable iff (rst)
    (regWr_ff && regNum_ff == `REG_PERIPH)
      |=> ({en_ff.intRef, en_ff.secondRef, en_ff.firstRef} ==
           {$past(shift_ff[4]), $past(shift_ff[1]), $past(shift_ff[0])})
          && $stable(en_ff.mem))
    else $error("peripheral enables not loaded correctly");

  a_spare_ignored: assert property (
    @(posedge mclk) disable iff (rst)
    (regWr_ff && regNum_ff == `REG_SPARE) |=> $stable(en_ff))
    else $error("spare register byte changed an enable");

  a_hold_enables: assert property (
    @(posedge mclk) disable iff (rst)
    !regWr_ff |=> $stable(en_ff))
    else $error("enables changed without a register write");

  a_ack_drive: assert property (
    @(posedge mclk) disable iff (rst)
    (state_ff == ST_RECV && sclFall && bitCnt_ff == `BYTE_BITS
     && !stopSeen && !startSeen && byteIdx_ff == 4'h0)
      |=> (sdaOe_ff == ($past(shift_ff) == `SLAVE_ADDR_BYTE)))
    else $error("address acknowledge wrong");

  a_ack_release: assert property (
    @(posedge mclk) disable iff (rst)
    (state_ff == ST_ACK && sclFall && !stopSeen && !startSeen)
      |=> !sdaOe_ff && state_ff == ST_RECV && bitCnt_ff == 4'h0)
    else $error("acknowledge not released on clock fall");

  a_oe_only_ack: assert property (
    @(posedge mclk) disable iff (rst)
    sdaOe_ff |-> (state_ff == ST_ACK))
    else $error("data line driven outside acknowledge");

  // Receiver framing: a refused transfer stays silent until the next
  // start or stop, so a stray byte can never be acknowledged.
  a_skip_silent: assert property (
    @(posedge mclk) disable iff (rst)
    (state_ff == ST_SKIP) |-> !sdaOe_ff)
    else $error("refused transfer was acknowledged");

  a_skip_hold: assert property (
    @(posedge mclk) disable iff (rst)
    (state_ff == ST_SKIP && !startSeen && !stopSeen) |=> (state_ff == ST_SKIP))
    else $error("refused transfer left without start or stop");

  a_stop_idle: assert property (
    @(posedge mclk) disable iff (rst)
    stopSeen |=> (state_ff == ST_IDLE) && !sdaOe_ff)
    else $error("stop condition did not return receiver to idle");

  a_start_restart: assert property (
    @(posedge mclk) disable iff (rst)
    startSeen |=> (state_ff == ST_RECV) && (byteIdx_ff == 4'h0)
                  && (bitCnt_ff == 4'h0) && !sdaOe_ff)
    else $error("start condition did not restart at address byte");

  a_ack_after_byte: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(sdaOe_ff) |-> ($past(bitCnt_ff) == `BYTE_BITS))
    else $error("acknowledge driven before a full byte");

  a_pull_only_low: assert property (
    @(posedge mclk) disable iff (rst)
    sdaOe_ff |-> !sdaOut_ff)
    else $error("data line driven high");

  a_reg_index: assert property (
    @(posedge mclk) disable iff (rst)
    regWr_ff |-> (byteIdx_ff >= `HEADER_BYTES)
                 && (4'(regNum_ff + `HEADER_BYTES) == byteIdx_ff))
    else $error("register byte stored at wrong register number");

  a_write_one_pulse: assert property (
    @(posedge mclk) disable iff (rst)
    regWr_ff |=> !regWr_ff)
    else $error("register write strobe longer than one cycle");

endmodule

// *** verification/serial_cfg_writer.sv ***
`timescale 1ns/1ps
module serial_cfg_writer (
  input  wire logic mclk,    // Bench clock used for bit timing.
  input  wire logic sdaWire, // Resolved data line level.
  output logic      scl,     // Serial clock, idle high.
  output logic      sdaRel   // Low pulls data low, high releases it.
);
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  // Ten mclk per phase keeps every level above the slave's sync minimum.
  task automatic phase(input int n = 10);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start_cond();
    sdaRel = 1'b1;
    scl = 1'b1;
    phase();
    sdaRel = 1'b0;
    phase();
    scl = 1'b0;
  endtask
  // Data moves a few cycles after the clock falls, so the synced copies
  // of the two lines never show a false start or stop.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      phase(4);
      sdaRel = b[i];
      phase();
      scl = 1'b1;
      phase();
      scl = 1'b0;
    end
    phase(4);
    sdaRel = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    ack = ~sdaWire;
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    phase(4);
    sdaRel = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sdaRel = 1'b1;
    phase();
  endtask
endmodule

// *** verification/test_clock_output_enable_regs.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  cmpCount++; \
  if ((gt) !== (ex)) begin \
    errTotal++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
  end
module test_clock_output_enable_regs
  import clock_output_enable_pkg::*;
;
  logic       mclk;
  logic       rst;
  logic       srcClk;
  logic       scl;
  logic       sdaRel;
  logic       sdaOut;
  logic       sdaOe;
  logic       sdaWire;
  logic [6:0] outs;
  logic [6:0] prevOuts;
  int         riseCnt [7];
  int         errTotal;
  int         cmpCount;
  int         cycles;

  // The data line has a pull-up; either party may pull it low.
  assign sdaWire = sdaRel & ~(sdaOe & ~sdaOut);

  clock_output_enable_regs i_clock_output_enable_regs (
    .mclk                  (mclk),
    .rst                   (rst),
    .srcClk                (srcClk),
    .sclIn                 (scl),
    .sdaIn                 (sdaWire),
    .sdaOut                (sdaOut),
    .sdaOe                 (sdaOe),
    .memoryClockEleven     (outs[6]),
    .memoryClockTen        (outs[5]),
    .memoryClockNine       (outs[4]),
    .memoryClockEight      (outs[3]),
    .interruptCtrlRefClock (outs[2]),
    .secondReferenceOut    (outs[1]),
    .firstReferenceOut     (outs[0])
  );

  serial_cfg_writer i_serial_cfg_writer (
    .mclk    (mclk),
    .sdaWire (sdaWire),
    .scl     (scl),
    .sdaRel  (sdaRel)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    srcClk = 1'b0;
    #1.7;
    forever #3 srcClk = ~srcClk;
  end

  always @(negedge srcClk) begin
    for (int i = 0; i < 7; i++)
      if (outs[i] === 1'b1 && prevOuts[i] !== 1'b1) riseCnt[i]++;
    prevOuts <= outs;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errTotal++;
      finalReport();
    end
  end

  task automatic finalReport();
    if (errTotal == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Waits out the enable sync, then watches each output for a while.
  task automatic checkOutputs(input clk_enables_t exp);
    logic [6:0] e;
    int         base [7];
    e = exp;
    repeat (20) @(negedge mclk);
    base = riseCnt;
    repeat (30) @(negedge mclk);
    for (int i = 0; i < 7; i++) begin
      `CHK("output running", e[i], 1'(riseCnt[i] != base[i]))
      `CHK("stopped output level", 1'b0, outs[i] & ~e[i])
    end
  endtask

  task automatic sendFrame(input int n, input logic [7:0] adr, r4, r5, r6,
                           input logic expAck);
    logic [7:0] fr [11];
    logic       ack;
    fr = '{adr, 8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, r4, r5, r6, 8'h5a};
    i_serial_cfg_writer.start_cond();
    for (int k = 0; k < n; k++) begin
      i_serial_cfg_writer.put_byte(fr[k], ack);
      `CHK("byte acknowledge", expAck, ack)
    end
    i_serial_cfg_writer.stop_cond();
  endtask

  task automatic testDefaults();
    checkOutputs(7'h7f);
  endtask

  // Reserved bits all high in register five and partly high in register four, a reserved byte of ones,
  // and one byte past the last register.
  task automatic testFullWrite();
    sendFrame(11, 8'hd2, 8'ha5, 8'hee, 8'hff, 1'b1);
    checkOutputs({4'h5, 1'b0, 1'b1, 1'b0});
  endtask

  task automatic testRefused();
    sendFrame(3, 8'hd3, 8'h0f, 8'h13, 8'h00, 1'b0);
    checkOutputs({4'h5, 1'b0, 1'b1, 1'b0});
  endtask

  // A frame that stops after register four leaves register five alone.
  task automatic testPartial();
    sendFrame(8, 8'hd2, 8'h0a, 8'h13, 8'h00, 1'b1);
    checkOutputs({4'ha, 1'b0, 1'b1, 1'b0});
  endtask

  task automatic testReenable();
    sendFrame(10, 8'hd2, 8'h0f, 8'h13, 8'h00, 1'b1);
    checkOutputs(7'h7f);
  endtask

  initial begin
    rst = 1'b1;
    errTotal = 0;
    cmpCount = 0;
    cycles = 0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    testDefaults();
    testFullWrite();
    testRefused();
    testPartial();
    testReenable();
    finalReport();
  end
endmodule
